// File: include/pdrl_pkg.sv
// Purpose: shared constants of the diagnostic, reset and LED register group
// Assumes: 16-bit registers reached by a simple register port
// Notes:   cycle counts are at the 10 MHz system clock
package pdrl_pkg;
  // register offsets
  localparam logic [15:0] OFF_BASIC_STS = 16'h0001;
  localparam logic [15:0] OFF_DIAG      = 16'h001e;
  localparam logic [15:0] OFF_RST       = 16'h001f;
  localparam logic [15:0] OFF_LED       = 16'h0025;
  localparam logic [15:0] OFF_CMPL      = 16'h0027;
  // field positions
  localparam int DIAG_START_BIT = 15;
  localparam int RESCAL_BIT     = 14;
  localparam int DIAG_DONE_BIT  = 1;
  localparam int DIAG_FAIL_BIT  = 0;
  localparam int HARD_RST_BIT   = 15;
  localparam int RESTART_BIT    = 14;
  localparam int POL_SWAP_BIT   = 9;
  localparam int LED_SRC_LSB    = 3;
  localparam int LED_ROUTE_BIT  = 0;
  // reset values
  localparam logic [15:0] DIAG_RESET  = 16'h0000;
  localparam logic [15:0] RST_RESET   = 16'h0000;
  localparam logic [15:0] LED_RESET   = 16'h0041;
  localparam logic [15:0] CMPL_RESET  = 16'h0000;
  localparam logic [3:0]  LED_SRC_RESET = 4'h8;
  // timing counts in sys_clk cycles, the stretch count in blink ticks
  localparam logic [3:0]  HARD_RST_CYC  = 4'h8;
  localparam logic [3:0]  RESTART_CYC   = 4'h4;
  localparam logic [11:0] BLINK_TICK    = 12'hfa0; // 400 us
  localparam logic [3:0]  STRETCH_TICKS = 4'h8;
  // led source codes
  typedef enum logic [3:0] {
    SRC_LINK = 4'h0, SRC_ACT = 4'h1, SRC_TX = 4'h2, SRC_RX = 4'h3,
    SRC_COL = 4'h4, SRC_SPD100 = 4'h5, SRC_SPD10 = 4'h6, SRC_FDX = 4'h7,
    SRC_LINK_BLINK = 4'h8, SRC_STRETCH = 4'h9, SRC_LINK100FD = 4'ha, SRC_LPI = 4'hb,
    SRC_MII_ERR = 4'hc, SRC_LINK_LOST = 4'hd, SRC_PRBS = 4'he
  } pdrl_src_t;
endpackage

// File: include/pdrl_led_if.sv
// Purpose: carries line status and led source selection to the led selector
// Assumes: all signals synchronous to sys_clk
// Notes:   status pulses are one cycle wide
interface pdrl_led_if;
  logic       link_up;
  logic       act_tx;
  logic       act_rx;
  logic       col_active;
  logic       speed_100;
  logic       full_duplex;
  logic       lpi_active;
  logic       mii_err;
  logic       prbs_err;
  logic       prbs_cnt_clr;
  logic       sts_read;
  logic       logic_clr;
  logic [3:0] src;
  logic       mled;
  modport ctl (output link_up, act_tx, act_rx, col_active, speed_100, full_duplex, lpi_active,
               mii_err, prbs_err, prbs_cnt_clr, sts_read, logic_clr, src, input mled);
  modport sel (input link_up, act_tx, act_rx, col_active, speed_100, full_duplex, lpi_active,
               mii_err, prbs_err, prbs_cnt_clr, sts_read, logic_clr, src, output mled);
endinterface

// File: src/pdrl_led_sel.sv
// Purpose: multi-function led source selection with latches and blink
// Assumes: single clock, logic_clr restarts all internal state except mled_reg
// Notes:   mled is registered, one cycle behind its sources
module pdrl_led_sel (
  input wire logic sys_clk,
  input wire logic resetn,
  pdrl_led_if.sel  lif
);
  logic [11:0] tick_cnt_reg;
  logic [3:0]  phase_reg;
  logic [3:0]  stretch_reg;
  logic        link_d_reg;
  logic        lost_reg;
  logic        prbs_reg;
  logic        mled_reg;
  logic        mled_next;
  wire         tick     = (tick_cnt_reg == pdrl_pkg::BLINK_TICK - 12'h001);
  wire         activity = lif.act_tx | lif.act_rx;
  wire         blink    = phase_reg[3];
  wire         link_fell = link_d_reg & ~lif.link_up;

  // blink divider and activity stretch
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tick_cnt_reg <= 12'h000;
      phase_reg    <= 4'h0;
      stretch_reg  <= 4'h0;
    end
    else if (lif.logic_clr)
    begin
      tick_cnt_reg <= 12'h000;
      phase_reg    <= 4'h0;
      stretch_reg  <= 4'h0;
    end
    else
    begin
      tick_cnt_reg <= tick ? 12'h000 : tick_cnt_reg + 12'h001;
      phase_reg    <= tick ? phase_reg + 4'h1 : phase_reg;
      if (activity)
        stretch_reg <= pdrl_pkg::STRETCH_TICKS;
      else if (tick && stretch_reg != 4'h0)
        stretch_reg <= stretch_reg - 4'h1;
    end
  end

  // sticky link-lost and prbs error latches, set wins over clear
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      link_d_reg <= 1'b0;
      lost_reg   <= 1'b0;
      prbs_reg   <= 1'b0;
    end
    else if (lif.logic_clr)
    begin
      link_d_reg <= 1'b0;
      lost_reg   <= 1'b0;
      prbs_reg   <= 1'b0;
    end
    else
    begin
      link_d_reg <= lif.link_up;
      lost_reg   <= link_fell | (lost_reg & ~lif.sts_read);
      prbs_reg   <= lif.prbs_err | (prbs_reg & ~lif.prbs_cnt_clr);
    end
  end

  // source decode
  always_comb
  begin
    case (lif.src)
      pdrl_pkg::SRC_LINK:       mled_next = lif.link_up;
      pdrl_pkg::SRC_ACT:        mled_next = activity;
      pdrl_pkg::SRC_TX:         mled_next = lif.act_tx;
      pdrl_pkg::SRC_RX:         mled_next = lif.act_rx;
      pdrl_pkg::SRC_COL:        mled_next = lif.col_active;
      pdrl_pkg::SRC_SPD100:     mled_next = lif.speed_100;
      pdrl_pkg::SRC_SPD10:      mled_next = ~lif.speed_100;
      pdrl_pkg::SRC_FDX:        mled_next = lif.full_duplex;
      pdrl_pkg::SRC_LINK_BLINK: mled_next = lif.link_up & ~(activity & blink);
      pdrl_pkg::SRC_STRETCH:    mled_next = (stretch_reg != 4'h0);
      pdrl_pkg::SRC_LINK100FD:  mled_next = lif.link_up & lif.speed_100 & lif.full_duplex;
      pdrl_pkg::SRC_LPI:        mled_next = lif.lpi_active;
      pdrl_pkg::SRC_MII_ERR:    mled_next = lif.mii_err;
      pdrl_pkg::SRC_LINK_LOST:  mled_next = lost_reg;
      pdrl_pkg::SRC_PRBS:       mled_next = prbs_reg;
      default:                  mled_next = 1'b0; // reserved code
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      mled_reg <= 1'b0;
    else
      mled_reg <= mled_next;
  end

  assign lif.mled = mled_reg;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  link_lost_hold_a: assert property ((lif.src == 4'hd) && link_fell && !lif.logic_clr
    ##1 (lif.src == 4'hd) && !lif.sts_read && !lif.logic_clr |=> lif.mled)
    else $error("link lost led not latched");
  prbs_hold_a: assert property (lif.prbs_err && !lif.logic_clr |=> prbs_reg [*2] or
    (prbs_reg ##1 (lif.prbs_cnt_clr || lif.logic_clr)) or (prbs_reg && (lif.prbs_cnt_clr || lif.logic_clr)))
    else $error("prbs error latch dropped");
  src_map_a: assert property ((lif.src == 4'h6) |=> lif.mled == !$past(lif.speed_100))
    else $error("speed 10 source wrong");
  reserved_dark_a: assert property ((lif.src == 4'hf) |=> !lif.mled)
    else $error("reserved source not dark");
  lost_cov_c: cover property ((lif.src == 4'hd) && link_fell ##1 lif.mled ##[1:20] lif.sts_read);
  prbs_cov_c: cover property ((lif.src == 4'he) && lif.prbs_err ##2 lif.mled);
endmodule

// File: src/pdrl_regs.sv
// Purpose: cable diagnostic, software reset and led control registers
// Assumes: register port strobes are one-cycle pulses synchronous to sys_clk
// Notes:   read data returns on the cycle after the read strobe
module pdrl_regs (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic [15:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        diag_done,
  input  wire logic        diag_fail,
  input  wire logic        link_up,
  input  wire logic        act_tx,
  input  wire logic        act_rx,
  input  wire logic        col_active,
  input  wire logic        speed_100,
  input  wire logic        full_duplex,
  input  wire logic        lpi_active,
  input  wire logic        mii_err,
  input  wire logic        prbs_err,
  input  wire logic        prbs_cnt_clr,
  input  wire logic        col_strap,
  output logic             diag_start,
  output logic             rescal_start,
  output logic             phy_hard_rst,
  output logic             logic_restart,
  output logic      [3:0]  compliance_cfg,
  output logic             led_pin_zero
);
  function automatic logic hit(input logic [15:0] addr, input logic [15:0] off);
    hit = (addr == off);
  endfunction

  logic        start_reg, rescal_reg, done_reg, fail_reg;
  logic        swap_reg, route_reg;
  logic [3:0]  src_reg;
  logic [3:0]  cmpl_reg;
  logic [3:0]  hard_cnt_reg, rst_cnt_reg;
  logic        hard_reg, restart_reg;
  logic        strap_reg, strap_taken_reg;
  logic        led_reg;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;

  pdrl_led_if lif ();

  // write and read decode
  wire wr_diag  = reg_wr & hit(reg_addr, pdrl_pkg::OFF_DIAG);
  wire wr_rst   = reg_wr & hit(reg_addr, pdrl_pkg::OFF_RST);
  wire wr_led   = reg_wr & hit(reg_addr, pdrl_pkg::OFF_LED);
  wire wr_cmpl  = reg_wr & hit(reg_addr, pdrl_pkg::OFF_CMPL);
  wire wr_hard  = wr_rst & reg_wdata[pdrl_pkg::HARD_RST_BIT] & ~hard_reg;
  wire wr_rest  = wr_rst & reg_wdata[pdrl_pkg::RESTART_BIT] & ~hard_reg & ~wr_hard & ~restart_reg;
  wire wr_start = wr_diag & reg_wdata[pdrl_pkg::DIAG_START_BIT];

  // next values of counters and led output
  wire [3:0] hard_cnt_next = wr_hard ? pdrl_pkg::HARD_RST_CYC :
                             (hard_cnt_reg != 4'h0) ? hard_cnt_reg - 4'h1 : 4'h0;
  wire [3:0] rst_cnt_next  = wr_rest ? pdrl_pkg::RESTART_CYC :
                             (rst_cnt_reg != 4'h0) ? rst_cnt_reg - 4'h1 : 4'h0;
  wire       active_low    = strap_reg ^ swap_reg;
  wire       led_raw       = route_reg ? lif.mled : link_up;
  wire       led_next      = led_raw ^ active_low;

  // read mux, reset bits show busy state
  always_comb
  begin
    rdata_next = 16'h0000;
    if (hit(reg_addr, pdrl_pkg::OFF_DIAG))
    begin
      rdata_next[pdrl_pkg::DIAG_START_BIT] = start_reg;
      rdata_next[pdrl_pkg::RESCAL_BIT]     = rescal_reg;
      rdata_next[pdrl_pkg::DIAG_DONE_BIT]  = done_reg;
      rdata_next[pdrl_pkg::DIAG_FAIL_BIT]  = fail_reg;
    end
    else if (hit(reg_addr, pdrl_pkg::OFF_RST))
    begin
      rdata_next[pdrl_pkg::HARD_RST_BIT] = hard_reg;
      rdata_next[pdrl_pkg::RESTART_BIT]  = restart_reg;
    end
    else if (hit(reg_addr, pdrl_pkg::OFF_LED))
    begin
      rdata_next[pdrl_pkg::POL_SWAP_BIT]              = swap_reg;
      rdata_next[pdrl_pkg::LED_SRC_LSB +: 4]          = src_reg;
      rdata_next[pdrl_pkg::LED_ROUTE_BIT]             = route_reg;
    end
    else if (hit(reg_addr, pdrl_pkg::OFF_CMPL))
      rdata_next[3:0] = cmpl_reg;
  end

  // cable diagnostic control and status, hardware events win
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      start_reg  <= pdrl_pkg::DIAG_RESET[pdrl_pkg::DIAG_START_BIT];
      rescal_reg <= pdrl_pkg::DIAG_RESET[pdrl_pkg::RESCAL_BIT];
      done_reg   <= pdrl_pkg::DIAG_RESET[pdrl_pkg::DIAG_DONE_BIT];
      fail_reg   <= pdrl_pkg::DIAG_RESET[pdrl_pkg::DIAG_FAIL_BIT];
    end
    else if (hard_reg)
    begin
      start_reg  <= pdrl_pkg::DIAG_RESET[pdrl_pkg::DIAG_START_BIT];
      rescal_reg <= pdrl_pkg::DIAG_RESET[pdrl_pkg::RESCAL_BIT];
      done_reg   <= pdrl_pkg::DIAG_RESET[pdrl_pkg::DIAG_DONE_BIT];
      fail_reg   <= pdrl_pkg::DIAG_RESET[pdrl_pkg::DIAG_FAIL_BIT];
    end
    else
    begin
      start_reg  <= diag_done ? 1'b0 : (wr_diag ? reg_wdata[pdrl_pkg::DIAG_START_BIT] : start_reg);
      rescal_reg <= wr_diag ? reg_wdata[pdrl_pkg::RESCAL_BIT] : rescal_reg;
      done_reg   <= diag_done | (done_reg & ~wr_start);
      fail_reg   <= (diag_done & diag_fail) | (fail_reg & ~wr_start & ~diag_done);
    end
  end

  // led and compliance configuration, restored by hard reset
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      swap_reg  <= pdrl_pkg::LED_RESET[pdrl_pkg::POL_SWAP_BIT];
      src_reg   <= pdrl_pkg::LED_SRC_RESET;
      route_reg <= pdrl_pkg::LED_RESET[pdrl_pkg::LED_ROUTE_BIT];
      cmpl_reg  <= pdrl_pkg::CMPL_RESET[3:0];
    end
    else if (hard_reg)
    begin
      swap_reg  <= pdrl_pkg::LED_RESET[pdrl_pkg::POL_SWAP_BIT];
      src_reg   <= pdrl_pkg::LED_SRC_RESET;
      route_reg <= pdrl_pkg::LED_RESET[pdrl_pkg::LED_ROUTE_BIT];
      cmpl_reg  <= pdrl_pkg::CMPL_RESET[3:0];
    end
    else
    begin
      if (wr_led)
      begin
        swap_reg  <= reg_wdata[pdrl_pkg::POL_SWAP_BIT];
        src_reg   <= reg_wdata[pdrl_pkg::LED_SRC_LSB +: 4];
        route_reg <= reg_wdata[pdrl_pkg::LED_ROUTE_BIT];
      end
      if (wr_cmpl)
        cmpl_reg <= reg_wdata[3:0];
    end
  end

  // self-clearing reset sequencers
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      hard_cnt_reg <= 4'h0;
      rst_cnt_reg  <= 4'h0;
      hard_reg     <= 1'b0;
      restart_reg  <= 1'b0;
    end
    else
    begin
      hard_cnt_reg <= hard_cnt_next;
      rst_cnt_reg  <= hard_reg ? 4'h0 : rst_cnt_next;
      hard_reg     <= (hard_cnt_next != 4'h0);
      restart_reg  <= ~hard_reg & (rst_cnt_next != 4'h0);
    end
  end

  // strap caught after reset release and after each hard reset
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      strap_reg       <= 1'b0;
      strap_taken_reg <= 1'b0;
    end
    else if (hard_reg)
      strap_taken_reg <= 1'b0;
    else if (!strap_taken_reg)
    begin
      strap_reg       <= col_strap;
      strap_taken_reg <= 1'b1;
    end
  end

  // output and read data registers
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      led_reg   <= 1'b0;
      rdata_reg <= 16'h0000;
    end
    else
    begin
      led_reg   <= led_next;
      rdata_reg <= reg_rd ? rdata_next : rdata_reg;
    end
  end

  // status towards the led selector
  assign lif.link_up      = link_up;
  assign lif.act_tx       = act_tx;
  assign lif.act_rx       = act_rx;
  assign lif.col_active   = col_active;
  assign lif.speed_100    = speed_100;
  assign lif.full_duplex  = full_duplex;
  assign lif.lpi_active   = lpi_active;
  assign lif.mii_err      = mii_err;
  assign lif.prbs_err     = prbs_err;
  assign lif.prbs_cnt_clr = prbs_cnt_clr;
  assign lif.sts_read     = reg_rd & hit(reg_addr, pdrl_pkg::OFF_BASIC_STS);
  assign lif.logic_clr    = hard_reg | restart_reg;
  assign lif.src          = src_reg;

  pdrl_led_sel u_sel (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .lif     (lif)
  );

  assign reg_rdata      = rdata_reg;
  assign diag_start     = start_reg;
  assign rescal_start   = rescal_reg;
  assign phy_hard_rst   = hard_reg;
  assign logic_restart  = restart_reg;
  assign compliance_cfg = cmpl_reg;
  assign led_pin_zero   = led_reg;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  start_clear_a: assert property (diag_done && !hard_reg |=> !diag_start)
    else $error("start not cleared on done");
  start_go_a: assert property (wr_start && !diag_done && !hard_reg |=> diag_start ##1 1'b1)
    else $error("start write ignored");
  done_set_a: assert property (diag_done && !hard_reg |=> done_reg ##0 diag_start == 1'b0)
    else $error("done flag not set");
  fail_set_a: assert property (diag_done && !hard_reg |=> fail_reg == $past(diag_fail))
    else $error("fail flag wrong");
  hard_seq_a: assert property (wr_hard |=> phy_hard_rst [*8] ##1 !phy_hard_rst && src_reg == 4'h8 && route_reg)
    else $error("hard reset sequence wrong");
  restart_seq_a: assert property (wr_rest && !hard_reg |=> logic_restart [*4] ##1 !logic_restart)
    else $error("restart sequence wrong");
  restart_keep_a: assert property (logic_restart && !hard_reg && !wr_led |=> $stable(src_reg))
    else $error("restart touched registers");
  led_pol_a: assert property (strap_taken_reg ##1 strap_taken_reg |-> led_pin_zero ==
    ($past(route_reg ? lif.mled : link_up) ^ $past(strap_reg ^ swap_reg)))
    else $error("led polarity or routing wrong");
  sc_read_a: assert property (reg_rd && hit(reg_addr, pdrl_pkg::OFF_RST) && !hard_reg && !restart_reg
    |=> reg_rdata[15:14] == 2'b00)
    else $error("reset bits not clear when idle");
  diag_cov_c: cover property (wr_start ##[1:50] diag_done && diag_fail);
  hard_cov_c: cover property (wr_hard ##[1:12] !phy_hard_rst);
  restart_cov_c: cover property (wr_rest ##5 !logic_restart);
endmodule

// File: bench/pdrl_regs_tb_top.sv
// Purpose: self-checking bench for the diagnostic, reset and led register group
// Assumes: inputs driven 1 ns after the rising edge, read data taken two edges after the strobe
// Notes:   line status inputs travel as one packed vector to keep the table scenarios short
module pdrl_regs_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic        sys_clk;
  logic        resetn;
  logic [15:0] reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        diag_done;
  logic        diag_fail;
  logic [7:0]  ln;
  logic        prbs_err;
  logic        prbs_cnt_clr;
  logic        col_strap;
  logic        diag_start;
  logic        rescal_start;
  logic        phy_hard_rst;
  logic        logic_restart;
  logic [3:0]  compliance_cfg;
  logic        led_pin_zero;
  int          n_mismatch;
  int          compares;
  int          cyc;

  // led source table: code, inputs for a dark led, inputs for a lit led
  localparam logic [3:0] CODE[13] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'ha, 4'hb, 4'hc, 4'hf};
  localparam logic [7:0] DARK[13] = '{8'h00, 8'h00, 8'h04, 8'h02, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h11, 8'h00,
                                      8'h00, 8'hff};
  localparam logic [7:0] LIT[13]  = '{8'h01, 8'h04, 8'h02, 8'h04, 8'h08, 8'h10, 8'h00, 8'h20, 8'h01, 8'h31, 8'h40,
                                      8'h80, 8'hff};

  pdrl_regs dut_u (
    .sys_clk        (sys_clk),
    .resetn         (resetn),
    .reg_addr       (reg_addr),
    .reg_wdata      (reg_wdata),
    .reg_wr         (reg_wr),
    .reg_rd         (reg_rd),
    .reg_rdata      (reg_rdata),
    .diag_done      (diag_done),
    .diag_fail      (diag_fail),
    .link_up        (ln[0]),
    .act_tx         (ln[1]),
    .act_rx         (ln[2]),
    .col_active     (ln[3]),
    .speed_100      (ln[4]),
    .full_duplex    (ln[5]),
    .lpi_active     (ln[6]),
    .mii_err        (ln[7]),
    .prbs_err       (prbs_err),
    .prbs_cnt_clr   (prbs_cnt_clr),
    .col_strap      (col_strap),
    .diag_start     (diag_start),
    .rescal_start   (rescal_start),
    .phy_hard_rst   (phy_hard_rst),
    .logic_restart  (logic_restart),
    .compliance_cfg (compliance_cfg),
    .led_pin_zero   (led_pin_zero)
  );

  // free-running system clock
  always #50 sys_clk = ~sys_clk;

  // hang guard, about fourteen times the expected run
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    if (n_mismatch == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // one write strobe, held for exactly one sampling edge
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    step(1);
    reg_wr = 1'b0;
  endtask

  task automatic rd_chk(input string nm, input logic [15:0] a, input logic [15:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    step(1);
    reg_rd = 1'b0;
    step(1);
    chk(nm, reg_rdata, exp);
  endtask

  // counts the cycles a self-clearing pulse stays high after its write
  task automatic pulse_len(input string nm, input logic [15:0] d, input logic [15:0] exp);
    logic [15:0] n;
    n = 16'h0000;
    step(1);
    wr(pdrl_pkg::OFF_RST, d);
    while (((d[15] && phy_hard_rst === 1'b1) || (d[14] && logic_restart === 1'b1)) && n < 16'h0020)
    begin
      step(1);
      n++;
    end
    chk(nm, n, exp);
  endtask

  task automatic led_chk(input string nm, input logic exp);
    step(3);
    chk(nm, {15'h0000, led_pin_zero}, {15'h0000, exp});
  endtask

  task automatic t_reset_values();
    rd_chk("diag_reg", pdrl_pkg::OFF_DIAG, 16'h0000);
    rd_chk("rst_reg", pdrl_pkg::OFF_RST, 16'h0000);
    rd_chk("led_reg", pdrl_pkg::OFF_LED, 16'h0041);
    rd_chk("cmpl_reg", pdrl_pkg::OFF_CMPL, 16'h0000);
    rd_chk("unmapped", 16'h0030, 16'h0000);
  endtask

  task automatic t_diag();
    wr(pdrl_pkg::OFF_DIAG, 16'h8000);
    chk("diag_start", {15'h0000, diag_start}, 16'h0001);
    step(3);
    diag_done = 1'b1;
    diag_fail = 1'b1;
    step(1);
    diag_done = 1'b0;
    diag_fail = 1'b0;
    chk("diag_start_clr", {15'h0000, diag_start}, 16'h0000);
    rd_chk("diag_fail_done", pdrl_pkg::OFF_DIAG, 16'h0003);
    wr(pdrl_pkg::OFF_DIAG, 16'h8000);
    rd_chk("diag_restart", pdrl_pkg::OFF_DIAG, 16'h8000);
    diag_done = 1'b1;
    step(1);
    diag_done = 1'b0;
    rd_chk("diag_pass", pdrl_pkg::OFF_DIAG, 16'h0002);
    wr(pdrl_pkg::OFF_DIAG, 16'h7fff);
    chk("rescal_start", {15'h0000, rescal_start}, 16'h0001);
    rd_chk("diag_ro_bits", pdrl_pkg::OFF_DIAG, 16'h4002);
    wr(pdrl_pkg::OFF_CMPL, 16'hffff);
    chk("cmpl_out", {12'h000, compliance_cfg}, 16'h000f);
    rd_chk("cmpl_bits", pdrl_pkg::OFF_CMPL, 16'h000f);
  endtask

  // every listed source code, dark then lit, strap low so active high
  task automatic t_led_table();
    for (int i = 0; i < 13; i++)
    begin
      wr(pdrl_pkg::OFF_LED, {9'h000, CODE[i], 3'h1});
      ln = DARK[i];
      led_chk("led_dark", 1'b0);
      ln = LIT[i];
      led_chk("led_lit", CODE[i] != 4'hf);
    end
  endtask

  task automatic t_latches();
    ln = 8'h01;
    wr(pdrl_pkg::OFF_LED, 16'h0069);
    // link dropped during the table, so the sticky latch must be read clear first
    rd_chk("basic_sts_pre", pdrl_pkg::OFF_BASIC_STS, 16'h0000);
    led_chk("lost_idle", 1'b0);
    ln = 8'h00;
    led_chk("lost_set", 1'b1);
    ln = 8'h01;
    led_chk("lost_held", 1'b1);
    rd_chk("basic_sts", pdrl_pkg::OFF_BASIC_STS, 16'h0000);
    led_chk("lost_clr", 1'b0);
    wr(pdrl_pkg::OFF_LED, 16'h0071);
    prbs_err = 1'b1;
    step(1);
    prbs_err = 1'b0;
    led_chk("prbs_set", 1'b1);
    step(5);
    led_chk("prbs_held", 1'b1);
    prbs_cnt_clr = 1'b1;
    step(1);
    prbs_cnt_clr = 1'b0;
    led_chk("prbs_clr", 1'b0);
  endtask

  task automatic t_restart();
    wr(pdrl_pkg::OFF_LED, 16'h0221);
    pulse_len("restart_len", 16'h4000, 16'h0004);
    rd_chk("restart_sc", pdrl_pkg::OFF_RST, 16'h0000);
    rd_chk("restart_keep", pdrl_pkg::OFF_LED, 16'h0221);
    // stretch state was cleared by the restart, one activity cycle lights it
    wr(pdrl_pkg::OFF_LED, 16'h0049);
    led_chk("stretch_idle", 1'b0);
    ln = 8'h03;
    step(1);
    ln = 8'h01;
    led_chk("stretch_held", 1'b1);
  endtask

  // hard reset with the strap now high, then polarity and routing
  task automatic t_hard_polarity();
    col_strap = 1'b1;
    wr(pdrl_pkg::OFF_CMPL, 16'h0005);
    pulse_len("hard_len", 16'h8000, 16'h0008);
    rd_chk("hard_sc", pdrl_pkg::OFF_RST, 16'h0000);
    rd_chk("hard_led", pdrl_pkg::OFF_LED, 16'h0041);
    rd_chk("hard_cmpl", pdrl_pkg::OFF_CMPL, 16'h0000);
    chk("hard_diag", {14'h0000, rescal_start, diag_start}, 16'h0000);
    ln = 8'h01;
    led_chk("pol_low", 1'b0);
    wr(pdrl_pkg::OFF_LED, 16'h0201);
    led_chk("pol_swap", 1'b1);
    wr(pdrl_pkg::OFF_LED, 16'h0000);
    led_chk("route_link_up", 1'b0);
    ln = 8'h00;
    led_chk("route_link_dn", 1'b1);
  endtask

  // main sequence
  initial
  begin
    sys_clk = 1'b0;
    resetn = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    diag_done = 1'b0;
    diag_fail = 1'b0;
    ln = 8'h00;
    prbs_err = 1'b0;
    prbs_cnt_clr = 1'b0;
    col_strap = 1'b0;
    n_mismatch = 0;
    compares = 0;
    cyc = 0;
    step(2);
    resetn = 1'b1;
    step(1);
    t_reset_values();
    t_diag();
    t_led_table();
    t_latches();
    t_restart();
    t_hard_polarity();
    wrap_up();
  end
endmodule
